// file: bench/fpc_classifier_sva.sv
/*
  Checker on the classifier ports: APB timing, refusal, egress stream.
  Assumes it is bound onto fpc_classifier; one clock, active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module fpc_classifier_sva
  import fpc_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              in_valid,
  input wire logic              in_ready,
  input wire logic              eg_valid,
  input wire logic              eg_ready,
  input wire logic [PORT_W-1:0] eg_port,
  input wire logic [PRIO_W-1:0] eg_prio,
  input wire logic [1:0]        eg_queue
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // regeneration enable as last written
  logic regen_ff;
  logic nxt_regen;
  always_comb begin
    nxt_regen = regen_ff;
    if (psel && penable && pready && pwrite && !pslverr && paddr == OFS_CTRL) begin
      nxt_regen = pwdata[CTRL_REGEN_BIT];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regen_ff <= 1'b0;
    end else begin
      regen_ff <= nxt_regen;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  a_apb_one_wait: assert property (s_setup ##1 s_wait |=> pready)
    else $error("pready missing in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside an access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (pready && (paddr > 8'h38 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped address not refused");
  a_mapped_ok: assert property (pready && paddr <= 8'h38 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped address refused");
  a_egress_hold: assert property (eg_valid && !eg_ready |=> eg_valid && $stable({eg_port, eg_prio, eg_queue}))
    else $error("egress tag changed before taken");
  a_queue_pairs: assert property (eg_valid && !regen_ff |-> eg_queue == eg_prio[2:1])
    else $error("queue does not match level pair");
  a_take_drops: assert property (in_valid && in_ready |=> !in_ready)
    else $error("in_ready stayed high after a take");
endmodule
bind fpc_classifier fpc_classifier_sva chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .in_valid(in_valid), .in_ready(in_ready), .eg_valid(eg_valid), .eg_ready(eg_ready),
  .eg_port(eg_port), .eg_prio(eg_prio), .eg_queue(eg_queue)
);
`default_nettype wire

// file: bench/fpc_far_end.sv
/*
  Far-side model: ingress parser handing headers, egress taker.
  Assumes one clock; the bench calls send() and sets hold to stall.
*/
`timescale 1ns/10ps
`default_nettype none
module fpc_far_end
  import fpc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  output logic                   in_valid,
  input  wire logic              in_ready,
  output logic [PORT_W-1:0]      in_port,
  output logic [IP_W-1:0]        in_src_ip,
  output logic [IP_W-1:0]        in_dst_ip,
  input  wire logic              eg_valid,
  output logic                   eg_ready,
  input  wire logic [PORT_W-1:0] eg_port,
  input  wire logic [PRIO_W-1:0] eg_prio,
  input  wire logic [1:0]        eg_queue
);
  logic       hold = 1'b0;
  logic [9:0] got[$];
  assign eg_ready = !hold;
  initial begin
    in_valid = 1'b0;
    in_port = '0;
    in_src_ip = '0;
    in_dst_ip = '0;
  end
  // header held until taken, then lines flip so stale values never match
  task send(input logic [PORT_W-1:0] p, input logic [IP_W-1:0] s, input logic [IP_W-1:0] d);
    @(posedge pclk);
    in_valid <= 1'b1;
    in_port <= p;
    in_src_ip <= s;
    in_dst_ip <= d;
    do @(posedge pclk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    in_port <= ~p;
    in_src_ip <= ~s;
    in_dst_ip <= ~d;
  endtask
  always @(posedge pclk) begin
    if (presetn && eg_valid && eg_ready) begin
      got.push_back({eg_port, eg_prio, eg_queue});
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_fpc_classifier.sv
/*
  Testbench: registers, classification, strict order, queue fill and
  regeneration. Assumes the far-side model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_fpc_classifier import fpc_pkg::*; ;
  localparam logic [31:0] IA = 32'h0A000001;
  localparam logic [31:0] IB = 32'h0A000002;
  localparam logic [31:0] IC = 32'h0A000003;
  localparam logic [31:0] IY = 32'h0A0000FF;
  logic              pclk = 1'b0;
  logic              presetn, psel, penable, pwrite, pready, pslverr, err;
  logic              in_valid, in_ready, eg_valid, eg_ready;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rdv, rg;
  logic [PORT_W-1:0] in_port, eg_port;
  logic [IP_W-1:0]   in_src_ip, in_dst_ip;
  logic [PRIO_W-1:0] eg_prio;
  logic [1:0]        eg_queue;
  int                bad_count = 0;
  int                check_count = 0;
  int                cp[13] = '{1, 1, 1, 1, 1, 1, 26, 0, 26, 27, 0, 1, 1};
  int                cl[13] = '{5, 2, 6, 2, 3, 3, 7, 0, 5, 0, 0, 6, 5};
  logic [31:0]       cs[13] = '{IY, IA, IB, IY, IC, IY, IY, IY, IY, IY, 32'h0, IB, IC};
  logic [31:0]       cd[13] = '{IA, IY, IY, IB, IY, IC, IY, IY, IA, IY, 32'h0, IA, IA};
  always #10 pclk = ~pclk;
  fpc_classifier dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_port(in_port),
    .in_src_ip(in_src_ip), .in_dst_ip(in_dst_ip), .eg_valid(eg_valid), .eg_ready(eg_ready),
    .eg_port(eg_port), .eg_prio(eg_prio), .eg_queue(eg_queue));
  fpc_far_end far_u (.pclk(pclk), .presetn(presetn), .in_valid(in_valid), .in_ready(in_ready),
    .in_port(in_port), .in_src_ip(in_src_ip), .in_dst_ip(in_dst_ip), .eg_valid(eg_valid),
    .eg_ready(eg_ready), .eg_port(eg_port), .eg_prio(eg_prio), .eg_queue(eg_queue));
  // ====
  // tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [9:0] tg(input int p, input int l, input int q);
    return {p[4:0], l[2:0], q[1:0]};
  endfunction
  task rx(input logic [9:0] e);
    for (int n = 0; n < 200 && far_u.got.size() == 0; n++) @(posedge pclk);
    chk(far_u.got.size() > 0 ? 32'(far_u.got.pop_front()) : 32'hFFFF, 32'(e));
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    close_out();
  end
  // ====
  // tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_REGEN, 0);
    chk(rdv, {8'h00, REGEN_RST});
    chk(err, 0);
    apb(1, 8'h40, 32'h1234);
    chk(err, 1);
    apb(0, 8'h40, 0);
    chk(err, 1);
    chk(rdv, 0);
    apb(1, OFS_PDEF0 + 8'h08, '1);
    apb(0, OFS_PDEF0 + 8'h08, 0);
    chk(rdv, 32'h0003FFFF);
    apb(1, OFS_ENT0, IA);
    apb(1, OFS_ENT0 + 8'h04, 32'h15);
    apb(1, OFS_ENT0 + 8'h08, IB);
    apb(1, OFS_ENT0 + 8'h0C, 32'h26);
    apb(1, OFS_ENT0 + 8'h10, IC);
    apb(1, OFS_ENT0 + 8'h14, 32'h33);
    apb(1, OFS_ENT0 + 8'h1C, 32'h07);
    apb(1, OFS_PDEF0, 32'h2);
    apb(1, OFS_PDEF0 + 8'h08, 32'h38000);
    apb(0, OFS_ENT0 + 8'h0C, 0);
    chk(rdv, 32'h26);
    $display("test registers done");
    for (int i = 0; i < 13; i++) begin
      far_u.send(5'(cp[i]), cs[i], cd[i]);
      rx(tg(cp[i], cl[i], cl[i] / 2));
    end
    $display("test classification done");
    far_u.hold <= 1'b1;
    for (int i = 0; i < 13; i++)
      far_u.send(i == 1 || i == 2 ? 5'd1 : i == 3 ? 5'd26 : 5'd0, IY, i == 2 ? IA : IY);
    repeat (4) @(posedge pclk);
    chk(in_ready, 0);
    apb(0, OFS_STATUS, 0);
    chk(rdv, 32'h00011118);
    far_u.hold <= 1'b0;
    rx(tg(0, 0, 0));
    rx(tg(26, 7, 3));
    rx(tg(1, 5, 2));
    rx(tg(1, 2, 1));
    repeat (9) rx(tg(0, 0, 0));
    apb(0, OFS_COUNT, 0);
    chk(rdv, 26);
    $display("test strict order done");
    rg = 0;
    for (int i = 0; i < 8; i++) rg[3*i +: 3] = 3'(7 - i);
    apb(1, OFS_REGEN, rg);
    apb(0, OFS_REGEN, 0);
    chk(rdv, rg);
    apb(1, OFS_CTRL, 1);
    for (int l = 0; l < 8; l++) begin
      apb(1, OFS_ENT0 + 8'h04, 32'h10 | l);
      far_u.send(5'd0, IY, IA);
      rx(tg(0, 7 - l, l / 2));
    end
    apb(1, OFS_CTRL, 0);
    far_u.send(5'd0, IY, IA);
    rx(tg(0, 7, 3));
    $display("test regeneration done");
    close_out();
  end
endmodule
`default_nettype wire

// file: logic/fpc_classifier.sv
/*
  Frame priority classifier: APB register file, address/port priority
  classification, four strict-priority egress queues and regeneration.
  Assumes the ingress parser presents one header per frame with
  valid/ready, and the egress queue logic takes tags with valid/ready.
*/
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// fifo
module fpc_fifo #(
  parameter int W = 8,
  parameter int D = 8,
  parameter int CW = 4
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [CW-1:0]      count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          push, pop;

  always_comb begin
    in_ready  = (cnt_ff != CW'(D));
    out_valid = (cnt_ff != '0);
    out_data  = mem_ff[rp_ff];
    count     = cnt_ff;
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    nxt_wp    = push ? AW'(wp_ff + 1'b1) : wp_ff;
    nxt_rp    = pop ? AW'(rp_ff + 1'b1) : rp_ff;
    nxt_cnt   = CW'(cnt_ff + CW'(push) - CW'(pop));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage needs no reset; only the pointers and the count carry control state
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
endmodule

// ==========================================================
// top
module fpc_classifier
  import fpc_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire logic [PORT_W-1:0]   in_port,
  input  wire logic [IP_W-1:0]     in_src_ip,
  input  wire logic [IP_W-1:0]     in_dst_ip,
  output logic                     eg_valid,
  input  wire logic                eg_ready,
  output logic [PORT_W-1:0]        eg_port,
  output logic [PRIO_W-1:0]        eg_prio,
  output logic [1:0]               eg_queue
);
  // ==========================================================
  // register file
  logic                 regen_en_ff, nxt_regen_en;
  logic [23:0]          regen_ff, nxt_regen;
  logic [IP_W-1:0]      ent_ip_ff [NUM_ENT];
  logic [IP_W-1:0]      nxt_ent_ip [NUM_ENT];
  logic [1:0]           ent_mode_ff [NUM_ENT];
  logic [1:0]           nxt_ent_mode [NUM_ENT];
  logic [PRIO_W-1:0]    ent_prio_ff [NUM_ENT];
  logic [PRIO_W-1:0]    nxt_ent_prio [NUM_ENT];
  logic [PRIO_W-1:0]    pdef_ff [NUM_PORTS];
  logic [PRIO_W-1:0]    nxt_pdef [NUM_PORTS];
  logic [31:0]          frames_ff, nxt_frames;
  logic                 pready_ff, nxt_pready;
  logic                 pslverr_ff, nxt_pslverr;
  logic [31:0]          prdata_ff, nxt_prdata;
  logic [Q_CNT_W-1:0]   q_cnt [NUM_Q];
  logic                 eg_valid_ff;
  logic                 wr_en, rd_hit;
  logic [31:0]          rd_val;
  logic                 cls_push;

  always_comb begin
    nxt_regen_en = regen_en_ff;
    nxt_regen    = regen_ff;
    nxt_ent_ip   = ent_ip_ff;
    nxt_ent_mode = ent_mode_ff;
    nxt_ent_prio = ent_prio_ff;
    nxt_pdef     = pdef_ff;
    nxt_frames   = cls_push ? frames_ff + 32'h1 : frames_ff;
    // one wait state: pready rises in the second access cycle
    nxt_pready   = psel && penable && !pready_ff;
    wr_en        = psel && penable && pready_ff && pwrite;
    rd_hit       = 1'b1;
    rd_val       = 32'h0;
    case (paddr)
      OFS_CTRL:   rd_val = {31'h0, regen_en_ff};
      OFS_STATUS: rd_val = {15'h0, eg_valid_ff, q_cnt[3], q_cnt[2], q_cnt[1], q_cnt[0]};
      OFS_COUNT:  rd_val = frames_ff;
      OFS_REGEN:  rd_val = {8'h0, regen_ff};
      default:    rd_hit = 1'b0;
    endcase
    for (int e = 0; e < NUM_ENT; e++) begin
      if (paddr == 8'(OFS_ENT0 + OFS_ENT_ST * e)) begin
        rd_hit = 1'b1;
        rd_val = ent_ip_ff[e];
      end
      if (paddr == 8'(OFS_ENT0 + OFS_ENT_ST * e + 4)) begin
        rd_hit = 1'b1;
        rd_val = {26'h0, ent_mode_ff[e], 1'b0, ent_prio_ff[e]};
      end
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (paddr == 8'(OFS_PDEF0 + 4 * (p / PORTS_PER_REG))) begin
        rd_hit = 1'b1;
        rd_val[3*(p % PORTS_PER_REG) +: 3] = pdef_ff[p];
      end
    end
    nxt_prdata  = (nxt_pready && !pwrite) ? rd_val : prdata_ff;
    nxt_pslverr = nxt_pready && !rd_hit;
    if (wr_en && rd_hit) begin
      if (paddr == OFS_CTRL) begin
        nxt_regen_en = pwdata[CTRL_REGEN_BIT];
      end
      if (paddr == OFS_REGEN) begin
        nxt_regen = pwdata[23:0];
      end
      for (int e = 0; e < NUM_ENT; e++) begin
        if (paddr == 8'(OFS_ENT0 + OFS_ENT_ST * e)) begin
          nxt_ent_ip[e] = pwdata;
        end
        if (paddr == 8'(OFS_ENT0 + OFS_ENT_ST * e + 4)) begin
          nxt_ent_prio[e] = pwdata[PRIO_W-1:0];
          nxt_ent_mode[e] = pwdata[ENT_MODE_LSB +: 2];
        end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (paddr == 8'(OFS_PDEF0 + 4 * (p / PORTS_PER_REG))) begin
          nxt_pdef[p] = pwdata[3*(p % PORTS_PER_REG) +: 3];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regen_en_ff <= 1'b0;
      regen_ff    <= REGEN_RST;
      for (int e = 0; e < NUM_ENT; e++) begin
        ent_ip_ff[e]   <= '0;
        ent_mode_ff[e] <= FPC_OFF;
        ent_prio_ff[e] <= PRIO_NONE;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        pdef_ff[p] <= PRIO_NONE;
      end
      frames_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      regen_en_ff <= nxt_regen_en;
      regen_ff    <= nxt_regen;
      ent_ip_ff   <= nxt_ent_ip;
      ent_mode_ff <= nxt_ent_mode;
      ent_prio_ff <= nxt_ent_prio;
      pdef_ff     <= nxt_pdef;
      frames_ff   <= nxt_frames;
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
      prdata_ff   <= nxt_prdata;
    end
  end

  // ==========================================================
  // classification stage
  logic                 cls_valid_ff, nxt_cls_valid;
  logic [TAG_W-1:0]     cls_tag_ff, nxt_cls_tag;
  logic                 in_ready_ff, nxt_in_ready;
  logic                 accept, hit, m;
  logic [PRIO_W-1:0]    best;
  logic [NUM_Q-1:0]     q_in_valid, q_in_ready, q_out_valid, q_out_ready;
  logic [TAG_W-1:0]     q_out_data [NUM_Q];
  logic [1:0]           cls_q;
  always_comb begin
    accept = in_valid && in_ready_ff;
    hit    = 1'b0;
    best   = PRIO_NONE;
    m      = 1'b0;
    for (int e = 0; e < NUM_ENT; e++) begin
      case (fpc_mode_t'(ent_mode_ff[e]))
        FPC_DST:    m = (in_dst_ip == ent_ip_ff[e]);
        FPC_SRC:    m = (in_src_ip == ent_ip_ff[e]);
        FPC_EITHER: m = (in_src_ip == ent_ip_ff[e]) || (in_dst_ip == ent_ip_ff[e]);
        default:    m = 1'b0;
      endcase
      // several hits: the highest level wins, seven being highest
      if (m && (!hit || ent_prio_ff[e] > best)) begin
        best = ent_prio_ff[e];
      end
      hit = hit || m;
    end
    if (!hit) begin
      if (in_port >= PORT_W'(1) && in_port <= PORT_W'(NUM_PORTS)) begin
        best = pdef_ff[in_port - PORT_W'(1)];
      end else begin
        best = PRIO_NONE;
      end
    end
    cls_q       = cls_tag_ff[PRIO_W-1:1];
    q_in_valid  = '0;
    q_in_valid[cls_q] = cls_valid_ff;
    cls_push    = cls_valid_ff && q_in_ready[cls_q];
    nxt_cls_tag = accept ? {in_port, best} : cls_tag_ff;
    nxt_cls_valid = accept || (cls_valid_ff && !cls_push);
    nxt_in_ready  = !nxt_cls_valid;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cls_valid_ff <= 1'b0;
      cls_tag_ff   <= '0;
      in_ready_ff  <= 1'b0;
    end else begin
      cls_valid_ff <= nxt_cls_valid;
      cls_tag_ff   <= nxt_cls_tag;
      in_ready_ff  <= nxt_in_ready;
    end
  end

  // ==========================================================
  // egress queues
  for (genvar q = 0; q < NUM_Q; q++) begin : g_q
    fpc_fifo #(.W(TAG_W), .D(Q_DEPTH), .CW(Q_CNT_W)) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (q_in_valid[q]),
      .in_ready  (q_in_ready[q]),
      .in_data   (cls_tag_ff),
      .out_valid (q_out_valid[q]),
      .out_ready (q_out_ready[q]),
      .out_data  (q_out_data[q]),
      .count     (q_cnt[q])
    );
  end

  // ==========================================================
  // strict priority scheduler and regeneration
  logic [PORT_W-1:0]    eg_port_ff, nxt_eg_port;
  logic [PRIO_W-1:0]    eg_prio_ff, nxt_eg_prio;
  logic [1:0]           eg_queue_ff, nxt_eg_queue;
  logic [1:0]           sel;
  logic                 load;
  logic                 nxt_eg_valid;
  logic [PRIO_W-1:0]    cur;
  always_comb begin
    sel = 2'h0;
    for (int q = 0; q < NUM_Q; q++) begin
      if (q_out_valid[q]) begin
        sel = 2'(q);
      end
    end
    load        = (!eg_valid_ff || eg_ready) && (q_out_valid != '0);
    q_out_ready = '0;
    q_out_ready[sel] = load;
    cur          = q_out_data[sel][PRIO_W-1:0];
    nxt_eg_valid = load || (eg_valid_ff && !eg_ready);
    nxt_eg_port  = load ? q_out_data[sel][TAG_W-1:PRIO_W] : eg_port_ff;
    nxt_eg_queue = load ? sel : eg_queue_ff;
    nxt_eg_prio  = eg_prio_ff;
    if (load) begin
      nxt_eg_prio = regen_en_ff ? regen_ff[3*cur +: 3] : cur;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eg_valid_ff <= 1'b0;
      eg_port_ff  <= '0;
      eg_prio_ff  <= PRIO_NONE;
      eg_queue_ff <= 2'h0;
    end else begin
      eg_valid_ff <= nxt_eg_valid;
      eg_port_ff  <= nxt_eg_port;
      eg_prio_ff  <= nxt_eg_prio;
      eg_queue_ff <= nxt_eg_queue;
    end
  end
  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign in_ready = in_ready_ff;
  assign eg_valid = eg_valid_ff;
  assign eg_port  = eg_port_ff;
  assign eg_prio  = eg_prio_ff;
  assign eg_queue = eg_queue_ff;
endmodule
`default_nettype wire

// file: logic/fpc_pkg.sv
/*
  Constants for the frame priority classifier: register map, field
  layout, reset values and the fixed sizes of the tables and queues.
  Assumes a 32-bit APB slave with byte addresses and word registers.
*/
`default_nettype none
package fpc_pkg;
  // ==========================================================
  // sizes
  localparam int PRIO_W    = 3;
  localparam int PORT_W    = 5;
  localparam int IP_W      = 32;
  localparam int NUM_PORTS = 26;
  localparam int NUM_ENT   = 4;
  localparam int NUM_Q     = 4;
  localparam int Q_DEPTH   = 8;
  localparam int Q_CNT_W   = 4;
  localparam int TAG_W     = PORT_W + PRIO_W;
  localparam int PORTS_PER_REG = 10;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;
  localparam logic [7:0] OFS_REGEN  = 8'h0C;
  localparam logic [7:0] OFS_ENT0   = 8'h10;
  localparam logic [7:0] OFS_ENT_ST = 8'h08;
  localparam logic [7:0] OFS_PDEF0  = 8'h30;

  // ==========================================================
  // field layout and reset values
  localparam int CTRL_REGEN_BIT = 0;
  localparam int ENT_MODE_LSB   = 4;
  localparam int STAT_EGV_BIT   = 16;
  localparam logic [23:0] REGEN_RST = 24'hFAC688;
  localparam logic [2:0]  PRIO_NONE = 3'h0;

  // ==========================================================
  // address match modes
  typedef enum logic [1:0] {
    FPC_OFF    = 2'b00,
    FPC_DST    = 2'b01,
    FPC_SRC    = 2'b10,
    FPC_EITHER = 2'b11
  } fpc_mode_t;
endpackage
`default_nettype wire
